//--- include/idad_pkg.sv
// Purpose: Shared constants and carrier types for the data space decoder.
// Assumes: Single core clock, no software-visible registers.
// Notes: Address windows and cycle counts are defined here; idad_props and idad_sfr_model repeat some of them as literals.
package idad_pkg;

  // ****************************************
  // Machine cycle timing
  // ****************************************
  localparam int unsigned IDAD_STATES_PER_CYCLE = 6;
  localparam logic [2:0] IDAD_STATE_FIRST = 3'h0;
  localparam logic [2:0] IDAD_STATE_LAST = 3'h5;

  // ****************************************
  // Internal data space windows
  // ****************************************
  localparam logic [7:0] IDAD_UPPER_BASE = 8'h80;
  localparam logic [7:0] IDAD_MAX_ADDR = 8'hFF;
  localparam int unsigned IDAD_LOWER_DEPTH = 128;
  localparam int unsigned IDAD_UPPER_DEPTH = 128;
  localparam int unsigned IDAD_SFR_DEPTH = 128;

  // ****************************************
  // External data space windows
  // ****************************************
  localparam logic [15:0] IDAD_EXTERNAL_DATA_SPACE_LAST = 16'h03C7;
  localparam logic [15:0] IDAD_PERIPH_BASE = 16'h6000;
  localparam logic [15:0] IDAD_PERIPH_LAST = 16'h7FFF;
  localparam int unsigned IDAD_EXTERNAL_DATA_SPACE_DEPTH = 968;

  // ****************************************
  // Reset values and sequencing
  // ****************************************
  localparam logic [7:0] IDAD_BYTE_RESET = 8'h00;
  localparam logic [3:0] IDAD_RESET_HOLD_CYCLES = 4'h8;

  // Kind of access requested by the execute stage.
  typedef enum logic [1:0] {
    IDAD_ACC_DIRECT,
    IDAD_ACC_INDIRECT,
    IDAD_ACC_XDPTR,
    IDAD_ACC_XPAGED
  } idad_mode_t;

  // Target region chosen by the decoder.
  typedef enum logic [2:0] {
    IDAD_TGT_NONE,
    IDAD_TGT_LOWER,
    IDAD_TGT_UPPER,
    IDAD_TGT_SFR,
    IDAD_TGT_EXTERNAL_DATA_SPACE,
    IDAD_TGT_PERIPH
  } idad_target_t;

  // One request from the execute stage.
  typedef struct packed {
    logic valid;
    logic write;
    idad_mode_t mode;
    logic [15:0] addr;
    logic sel_r1;
    logic [7:0] wdata;
    logic [7:0] cycles;
  } idad_req_t;

  // Routing to the outside targets.
  typedef struct packed {
    logic sfr_strobe;
    logic periph_strobe;
    logic write;
    logic [7:0] sfr_addr;
    logic [4:0] periph_region;
    logic [7:0] periph_offset;
    logic [7:0] wdata;
  } idad_route_t;

endpackage

//--- hw/idad_state_seq.sv
// Purpose: Six-state machine cycle sequencer.
// Assumes: Runs on every core clock edge.
// Notes: Flags each machine cycle end; the decoder counts cycles for multi-cycle instructions.
`timescale 1ns/1ps
module idad_state_seq
  import idad_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic run,
  output logic [2:0] state,
  output logic cycle_end
);

  logic [2:0] state_ff;
  logic [2:0] nxt_state;

  // Wrap after the last state so every machine cycle has exactly six states.
  always_comb begin
    if (!run) begin
      nxt_state = IDAD_STATE_FIRST;
    end else if (state_ff == IDAD_STATE_LAST) begin
      nxt_state = IDAD_STATE_FIRST;
    end else begin
      nxt_state = state_ff + 3'h1;
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= IDAD_STATE_FIRST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state = state_ff;
  assign cycle_end = run && (state_ff == IDAD_STATE_LAST);

endmodule

//--- hw/internal_data_space_address_decode.sv
// Purpose: Internal and external data space decode, machine cycle timing and pin control.
// Assumes: Requests come from the execute stage on sys_clk; pins are asynchronous.
// Notes: Requests are held by the requester until done pulses.
`timescale 1ns/1ps
// Notes on behaviour
// - Machine cycle is six states S1..S6.
// - Instructions take whole machine cycles, at least one.
// - 384 internal bytes, incl. 128 SFR bytes.
// - One 64 KB external space, two-byte address.
// - Direct address comes from instruction field.
// - Direct 80h..FFh goes to SFR space.
// - Indirect 80h..FFh goes to upper RAM.
// - 00h..7Fh always reaches lower RAM.
// - Reset pin low: oscillator, sources, pads off.
// - Falling reset pin edge starts internal reset.
// - Second irq pin floats host, powers down.
// - First irq pin is GPIO and irq source.
// - Port3 bit1 is GPIO or UART TX.
// - 6000h..7FFFh maps to peripherals, 256-byte regions.
// - Paged mode: page register high, R0/low.
// - Only 0000h..03C7h are valid external RAM.
module internal_data_space_address_decode
  import idad_pkg::*;
#(
  parameter int unsigned EXTERNAL_DATA_SPACE_DEPTH = IDAD_EXTERNAL_DATA_SPACE_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input idad_req_t req,
  input wire logic [7:0] ptr_r0,
  input wire logic [7:0] ptr_r1,
  input wire logic [7:0] xdata_page_register,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_implemented,
  input wire logic [7:0] periph_rdata,
  input wire logic reset_powerdown_pin,
  input wire logic host_float_powerdown_pin_in,
  input wire logic host_float_enable,
  input wire logic external_irq_pin_a_in,
  input wire logic external_irq_pin_a_out,
  input wire logic external_irq_pin_a_oe_req,
  input wire logic port3_bit1_in,
  input wire logic port3_bit1_gpio_out,
  input wire logic port3_bit1_gpio_oe,
  input wire logic uart2_tx,
  input wire logic port3_bit1_uart_sel,
  output logic [2:0] mc_state,
  output logic done,
  output logic [7:0] rdata,
  output idad_target_t target,
  output idad_route_t route,
  output logic osc_enable,
  output logic current_src_enable,
  output logic pad_input_enable,
  output logic core_reset,
  output logic host_output_float,
  output logic powerdown_hold,
  output logic external_irq_pin_a_out_pin,
  output logic external_irq_pin_a_oe,
  output logic external_irq_a_level,
  output logic external_irq_a_fall,
  output logic host_float_powerdown_level,
  output logic port3_bit1_in_sync,
  output logic port3_bit1_out,
  output logic port3_bit1_oe
);

  // ****************************************
  // Storage
  // ****************************************
  // Lower and upper blocks make 256 RAM bytes; SFRs add 128 more.
  logic [7:0] lower_ram [IDAD_LOWER_DEPTH];
  logic [7:0] upper_ram [IDAD_UPPER_DEPTH];
  logic [7:0] external_data_space [EXTERNAL_DATA_SPACE_DEPTH];

  logic [1:0] rstpin_sync_ff;
  logic [1:0] fltpin_sync_ff;
  logic [1:0] irqa_sync_ff;
  logic [1:0] p31_sync_ff;
  logic rstpin_prev_ff;
  logic irqa_prev_ff;
  logic [3:0] reset_cnt_ff;
  logic [7:0] cycle_cnt_ff;
  logic done_ff;
  logic [7:0] rdata_ff;
  logic busy;
  logic cycle_end;
  logic [15:0] eff_addr;
  idad_target_t tgt;
  logic [7:0] rd_mux;
  logic last_cycle;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Every pin passes two flops before use.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstpin_sync_ff <= 2'h0;
      fltpin_sync_ff <= 2'h0;
      irqa_sync_ff <= 2'h3;
      p31_sync_ff <= 2'h3;
    end else begin
      rstpin_sync_ff <= {rstpin_sync_ff[0], reset_powerdown_pin};
      fltpin_sync_ff <= {fltpin_sync_ff[0], host_float_powerdown_pin_in};
      irqa_sync_ff <= {irqa_sync_ff[0], external_irq_pin_a_in};
      p31_sync_ff <= {p31_sync_ff[0], port3_bit1_in};
    end
  end

  // Edge history taken from the second stage only.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstpin_prev_ff <= 1'b0;
      irqa_prev_ff <= 1'b1;
    end else begin
      rstpin_prev_ff <= rstpin_sync_ff[1];
      irqa_prev_ff <= irqa_sync_ff[1];
    end
  end

  // ****************************************
  // Reset and power-down pin
  // ****************************************
  // A falling edge reloads the hold counter; it runs out after the pin rises.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_cnt_ff <= IDAD_RESET_HOLD_CYCLES;
    end else if (rstpin_prev_ff && !rstpin_sync_ff[1]) begin
      reset_cnt_ff <= IDAD_RESET_HOLD_CYCLES;
    end else if (rstpin_sync_ff[1] && reset_cnt_ff != 4'h0) begin
      reset_cnt_ff <= reset_cnt_ff - 4'h1;
    end
  end

  // Low pin shuts the analog side down.
  assign osc_enable = rstpin_sync_ff[1];
  assign current_src_enable = rstpin_sync_ff[1];
  assign pad_input_enable = rstpin_sync_ff[1];
  assign core_reset = !rstpin_sync_ff[1] || (reset_cnt_ff != 4'h0);

  // ****************************************
  // Interrupt and port pins
  // ****************************************
  // Second irq pin floats host outputs and holds state in power-down.
  assign host_float_powerdown_level = fltpin_sync_ff[1];
  assign host_output_float = host_float_enable && fltpin_sync_ff[1];
  assign powerdown_hold = host_float_enable && fltpin_sync_ff[1];

  // First irq pin is a GPIO and feeds the core interrupt logic.
  assign external_irq_pin_a_out_pin = external_irq_pin_a_out;
  assign external_irq_pin_a_oe = external_irq_pin_a_oe_req && pad_input_enable;
  assign external_irq_a_level = irqa_sync_ff[1];
  assign external_irq_a_fall = irqa_prev_ff && !irqa_sync_ff[1];

  // Port 3 bit 1 mux; UART mode drives the line while pad_input_enable is high.
  assign port3_bit1_in_sync = p31_sync_ff[1];
  assign port3_bit1_out = port3_bit1_uart_sel ? uart2_tx : port3_bit1_gpio_out;
  assign port3_bit1_oe = (port3_bit1_uart_sel || port3_bit1_gpio_oe) && pad_input_enable;

  // ****************************************
  // Machine cycle sequencer
  // ****************************************
  assign busy = req.valid && !core_reset && !done_ff;

  idad_state_seq i_idad_state_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(busy),
    .state(mc_state),
    .cycle_end(cycle_end)
  );

  // Count machine cycles; a zero request is taken as one cycle.
  assign last_cycle = cycle_end && (cycle_cnt_ff + 8'h1 >= req.cycles);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cycle_cnt_ff <= 8'h00;
    end else if (!busy || last_cycle) begin
      cycle_cnt_ff <= 8'h00;
    end else if (cycle_end) begin
      cycle_cnt_ff <= cycle_cnt_ff + 8'h1;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Paged mode builds the address from page register and R0/.
  always_comb begin
    eff_addr = req.addr;
    if (req.mode == IDAD_ACC_XPAGED) begin
      eff_addr = {xdata_page_register, req.sel_r1 ? ptr_r1 : ptr_r0};
    end else if (req.mode == IDAD_ACC_INDIRECT) begin
      eff_addr = {8'h00, req.sel_r1 ? ptr_r1 : ptr_r0};
    end
  end

  // Region selection by mode and address.
  always_comb begin
    tgt = IDAD_TGT_NONE;
    case (req.mode)
      IDAD_ACC_DIRECT, IDAD_ACC_INDIRECT: begin
        if (eff_addr[7:0] < IDAD_UPPER_BASE) begin
          tgt = IDAD_TGT_LOWER;
        end else if (req.mode == IDAD_ACC_DIRECT) begin
          tgt = IDAD_TGT_SFR;
        end else begin
          tgt = IDAD_TGT_UPPER;
        end
      end
      IDAD_ACC_XDPTR, IDAD_ACC_XPAGED: begin
        if (eff_addr <= IDAD_EXTERNAL_DATA_SPACE_LAST) begin
          tgt = IDAD_TGT_EXTERNAL_DATA_SPACE;
        end else if (eff_addr >= IDAD_PERIPH_BASE && eff_addr <= IDAD_PERIPH_LAST) begin
          tgt = IDAD_TGT_PERIPH;
        end
      end
      default: begin
        tgt = IDAD_TGT_NONE;
      end
    endcase
  end

  assign target = tgt;

  // Outside routing pulses during the final state of the access.
  always_comb begin
    route.sfr_strobe = last_cycle && (tgt == IDAD_TGT_SFR) && sfr_implemented;
    route.periph_strobe = last_cycle && (tgt == IDAD_TGT_PERIPH);
    route.write = req.write;
    route.sfr_addr = eff_addr[7:0];
    route.periph_region = eff_addr[12:8];
    route.periph_offset = eff_addr[7:0];
    route.wdata = req.wdata;
  end

  // Read mux; anything unmapped reads zero.
  always_comb begin
    rd_mux = IDAD_BYTE_RESET;
    case (tgt)
      IDAD_TGT_LOWER: rd_mux = lower_ram[eff_addr[6:0]];
      IDAD_TGT_UPPER: rd_mux = upper_ram[eff_addr[6:0]];
      IDAD_TGT_SFR: rd_mux = sfr_implemented ? sfr_rdata : IDAD_BYTE_RESET;
      IDAD_TGT_EXTERNAL_DATA_SPACE: rd_mux = external_data_space[eff_addr[9:0]];
      IDAD_TGT_PERIPH: rd_mux = periph_rdata;
      default: rd_mux = IDAD_BYTE_RESET;
    endcase
  end

  // ****************************************
  // RAM writes and answer
  // ****************************************
  // Writes land in the final state only, so a cycle is never cut short.
  always_ff @(posedge sys_clk) begin
    if (last_cycle && req.write) begin
      if (tgt == IDAD_TGT_LOWER) begin
        lower_ram[eff_addr[6:0]] <= req.wdata;
      end
      if (tgt == IDAD_TGT_UPPER) begin
        upper_ram[eff_addr[6:0]] <= req.wdata;
      end
      if (tgt == IDAD_TGT_EXTERNAL_DATA_SPACE) begin
        external_data_space[eff_addr[9:0]] <= req.wdata;
      end
    end
  end

  // Done pulses one cycle after the last state; read data is held until the next read answer.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_ff <= 1'b0;
      rdata_ff <= IDAD_BYTE_RESET;
    end else begin
      done_ff <= last_cycle;
      if (last_cycle && !req.write) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign done = done_ff;
  assign rdata = rdata_ff;

endmodule

//--- verif/idad_props.sv
// Purpose: Port-level checks of machine cycle timing, routing and pin control.
// Assumes: Bound to the decoder top; one clock domain.
// Notes: Routing checks apply only while a taken request is held.
`timescale 1ns/1ps
module idad_props
  import idad_pkg::*;
#(
  parameter int unsigned EXTERNAL_DATA_SPACE_DEPTH = IDAD_EXTERNAL_DATA_SPACE_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input idad_req_t req,
  input wire logic [7:0] ptr_r0,
  input wire logic [7:0] ptr_r1,
  input wire logic [2:0] mc_state,
  input wire logic done,
  input idad_target_t target,
  input idad_route_t route,
  input wire logic osc_enable,
  input wire logic pad_input_enable,
  input wire logic core_reset,
  input wire logic reset_powerdown_pin
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic act;
  logic [7:0] ind;
  // A request counts only once the core is out of reset.
  assign act = req.valid && !core_reset;
  assign ind = req.sel_r1 ? ptr_r1 : ptr_r0;
  sequence s_start; act && mc_state == 3'h0 && !done; endsequence
  sequence s_quiet; !done [*5]; endsequence
  property p_state_max; mc_state <= 3'h5; endproperty
  a_state_max: assert property (p_state_max) else $error("state past six");
  property p_state_step; mc_state inside {[3'h1:3'h4]} |=> mc_state == $past(mc_state) + 3'h1;
  endproperty
  a_state_step: assert property (p_state_step) else $error("state skipped");
  property p_min_cycle; s_start |=> s_quiet; endproperty
  a_min_cycle: assert property (p_min_cycle) else $error("done too early");
  property p_done_end; done |-> $past(mc_state) == 3'h5 ##1 !done; endproperty
  a_done_end: assert property (p_done_end) else $error("done off cycle end");
  property p_dir_sfr; act && req.mode == IDAD_ACC_DIRECT && req.addr[7] |-> target == IDAD_TGT_SFR;
  endproperty
  a_dir_sfr: assert property (p_dir_sfr) else $error("direct high not sfr");
  property p_ind_up; act && req.mode == IDAD_ACC_INDIRECT && ind[7] |-> target == IDAD_TGT_UPPER;
  endproperty
  a_ind_up: assert property (p_ind_up) else $error("indirect high not upper");
  property p_lower;
    act && (req.mode == IDAD_ACC_DIRECT ? !req.addr[7] : req.mode == IDAD_ACC_INDIRECT && !ind[7])
    |-> target == IDAD_TGT_LOWER;
  endproperty
  a_lower: assert property (p_lower) else $error("low address not lower");
  property p_periph; act && req.mode == IDAD_ACC_XDPTR && req.addr[15:13] == 3'h3
    |-> target == IDAD_TGT_PERIPH && route.periph_region == req.addr[12:8];
  endproperty
  a_periph: assert property (p_periph) else $error("periph window wrong");
  property p_strobe; route.sfr_strobe |-> target == IDAD_TGT_SFR && mc_state == 3'h5; endproperty
  a_strobe: assert property (p_strobe) else $error("sfr strobe misplaced");
  property p_pin_off; !reset_powerdown_pin [*3] |-> !osc_enable && !pad_input_enable; endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin low not off");
  property p_core_rst; !osc_enable |-> core_reset [*8]; endproperty
  a_core_rst: assert property (p_core_rst) else $error("reset phase short");
endmodule
bind internal_data_space_address_decode idad_props #(.EXTERNAL_DATA_SPACE_DEPTH(EXTERNAL_DATA_SPACE_DEPTH)) i_idad_props (
  .sys_clk(sys_clk), .rst(rst), .req(req), .ptr_r0(ptr_r0), .ptr_r1(ptr_r1),
  .mc_state(mc_state), .done(done), .target(target), .route(route),
  .osc_enable(osc_enable), .pad_input_enable(pad_input_enable),
  .core_reset(core_reset), .reset_powerdown_pin(reset_powerdown_pin));

//--- verif/idad_sfr_model.sv
// Purpose: Special function and peripheral responder beside the decoder.
// Assumes: Answers combinationally, as the decoder expects.
// Notes: Only 80h..BFh exist; others answer junk so zeroing shows.
`timescale 1ns/1ps
module idad_sfr_model
  import idad_pkg::*;
(
  input wire logic sys_clk,
  input idad_route_t route,
  output logic [7:0] sfr_rdata,
  output logic sfr_implemented,
  output logic [7:0] periph_rdata
);
  // ****************************************
  // Storage and answers
  // ****************************************
  logic [7:0] mem [0:63];
  // Junk on missing addresses is the inverse of the address, zero only at FFh.
  assign sfr_implemented = route.sfr_addr < 8'hC0;
  assign sfr_rdata = sfr_implemented ? mem[route.sfr_addr[5:0]] : ~route.sfr_addr;
  assign periph_rdata = 8'hC3 ^ route.periph_offset ^ {3'h0, route.periph_region};
  // Writes land only on the decoder's strobe.
  always_ff @(posedge sys_clk) begin
    if (route.sfr_strobe && route.write && sfr_implemented) begin
      mem[route.sfr_addr[5:0]] <= route.wdata;
    end
  end
endmodule

//--- verif/tb_internal_data_space_address_decode.sv
// Purpose: Directed bench for data space decode, cycle timing and pins.
// Assumes: Inputs change on the falling edge.
// Notes: One idle cycle separates requests.
`timescale 1ns/1ps
module tb_internal_data_space_address_decode
  import idad_pkg::*;
;
  // ****************************************
  // Signals and helpers
  // ****************************************
  logic sys_clk, rst, pin, hfe, hfp, ia_in, ia_o, ia_oe, p_in, p_go, p_goe, tx, usel, done;
  logic osc, cur, pad, crst, flt, pdh, ia_pin, ia_poe, ia_lvl, ia_fall, p_sync, p_out;
  logic [7:0] r0, r1, pg, sd, pd, rdata, q;
  logic imp, p_oe, hfl;
  idad_req_t req;
  idad_route_t route;
  int bad_count, n_tests, cyc, k;
  internal_data_space_address_decode i_internal_data_space_address_decode (.sys_clk(sys_clk), .rst(rst), .req(req),
    .ptr_r0(r0), .ptr_r1(r1), .xdata_page_register(pg), .sfr_rdata(sd), .sfr_implemented(imp),
    .periph_rdata(pd), .reset_powerdown_pin(pin), .host_float_powerdown_pin_in(hfp),
    .host_float_enable(hfe), .external_irq_pin_a_in(ia_in), .external_irq_pin_a_out(ia_o),
    .external_irq_pin_a_oe_req(ia_oe), .port3_bit1_in(p_in), .port3_bit1_gpio_out(p_go),
    .port3_bit1_gpio_oe(p_goe), .uart2_tx(tx), .port3_bit1_uart_sel(usel), .mc_state(),
    .done(done), .rdata(rdata), .target(), .route(route), .osc_enable(osc),
    .current_src_enable(cur), .pad_input_enable(pad), .core_reset(crst),
    .host_output_float(flt), .powerdown_hold(pdh), .external_irq_pin_a_out_pin(ia_pin),
    .external_irq_pin_a_oe(ia_poe), .external_irq_a_level(ia_lvl),
    .external_irq_a_fall(ia_fall), .host_float_powerdown_level(hfl),
    .port3_bit1_in_sync(p_sync), .port3_bit1_out(p_out), .port3_bit1_oe(p_oe));
  idad_sfr_model i_idad_sfr_model (.sys_clk(sys_clk), .route(route), .sfr_rdata(sd),
    .sfr_implemented(imp), .periph_rdata(pd));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Holds the request until done, as the requester must, then drops it.
  task automatic op(input logic w, input idad_mode_t m, input logic [15:0] a, input logic s,
    input logic [7:0] d, input logic [7:0] n);
    @(negedge sys_clk);
    req = '{1'b1, w, m, a, s, d, n};
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (done !== 1'b1 && k < 200);
    // A request that never finishes is a failure in its own right.
    if (done !== 1'b1) begin
      bad_count++;
    end
    q = rdata;
    @(negedge sys_clk);
    req.valid = 1'b0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_timing();
    op(1'b1, IDAD_ACC_DIRECT, 16'h0010, 1'b0, 8'h11, 8'h00);
    check("len0", 16'(k), 16'h0006);
    op(1'b1, IDAD_ACC_DIRECT, 16'h0010, 1'b0, 8'h11, 8'h03);
    check("len3", 16'(k), 16'h0012);
  endtask
  task automatic t_internal_data_space();
    op(1'b1, IDAD_ACC_DIRECT, 16'h007F, 1'b0, 8'hA5, 8'h01);
    r0 = 8'h7F;
    op(1'b0, IDAD_ACC_INDIRECT, 16'h0033, 1'b0, 8'h00, 8'h01);
    check("ind_low", {8'h00, q}, 16'h00A5);
    r1 = 8'h80;
    op(1'b1, IDAD_ACC_INDIRECT, 16'h0000, 1'b1, 8'h3C, 8'h01);
    op(1'b1, IDAD_ACC_DIRECT, 16'h0080, 1'b0, 8'h77, 8'h01);
    op(1'b0, IDAD_ACC_DIRECT, 16'h5580, 1'b0, 8'h00, 8'h01);
    check("dir_sfr", {8'h00, q}, 16'h0077);
    op(1'b0, IDAD_ACC_INDIRECT, 16'h0000, 1'b1, 8'h00, 8'h02);
    check("ind_up", {8'h00, q}, 16'h003C);
    op(1'b0, IDAD_ACC_DIRECT, 16'hFF7F, 1'b0, 8'h00, 8'h01);
    check("dir_low", {8'h00, q}, 16'h00A5);
    op(1'b1, IDAD_ACC_DIRECT, 16'h00F0, 1'b0, 8'h55, 8'h01);
    op(1'b0, IDAD_ACC_DIRECT, 16'h00F0, 1'b0, 8'h00, 8'h01);
    check("sfr_none", {8'h00, q}, 16'h0000);
  endtask
  task automatic t_xdata();
    op(1'b1, IDAD_ACC_XDPTR, 16'h03C7, 1'b0, 8'h5A, 8'h02);
    op(1'b1, IDAD_ACC_XDPTR, 16'h03C8, 1'b0, 8'h66, 8'h02);
    op(1'b0, IDAD_ACC_XDPTR, 16'h03C8, 1'b0, 8'h00, 8'h02);
    check("x_over", {8'h00, q}, 16'h0000);
    op(1'b0, IDAD_ACC_XDPTR, 16'h6312, 1'b0, 8'h00, 8'h02);
    check("x_per", {8'h00, q}, 16'h00D2);
    pg = 8'h61;
    r0 = 8'h34;
    op(1'b0, IDAD_ACC_XPAGED, 16'h0000, 1'b0, 8'h00, 8'h02);
    check("pg_per", {8'h00, q}, 16'h00F6);
    pg = 8'h03;
    r1 = 8'hC7;
    op(1'b0, IDAD_ACC_XPAGED, 16'h0000, 1'b1, 8'h00, 8'h02);
    check("pg_ram", {8'h00, q}, 16'h005A);
  endtask
  task automatic t_pins();
    pin = 1'b0;
    wt(4);
    check("off", {osc, cur, pad, crst}, 16'h0001);
    pin = 1'b1;
    wt(5);
    check("rst_hold", {15'h0, crst}, 16'h0001);
    for (k = 0; k < 20 && crst !== 1'b0; k++) wt(1);
    check("on", {osc, cur, pad, crst}, 16'h000E);
    ia_in = 1'b0;
    for (k = 0; k < 6 && ia_fall !== 1'b1; k++) wt(1);
    check("fall", {ia_fall, ia_lvl}, 16'h0002);
    wt(1);
    check("fall1", {15'h0, ia_fall}, 16'h0000);
    {ia_o, ia_oe, hfe, hfp, p_in} = 5'b11110;
    wt(3);
    check("gpio", {ia_pin, ia_poe, flt, pdh, p_sync, p_oe, hfl}, 16'h0079);
    // UART select with the GPIO value low, so only the transmit path can show a one.
    {hfp, usel, tx, p_go, p_in, ia_o} = 6'b011010;
    wt(3);
    check("flt0", {ia_pin, flt, pdh, p_out, p_sync, p_oe, hfl}, 16'h000E);
    {tx, usel, p_go, p_goe} = 4'b0011;
    wt(1);
    check("p_gpio", {14'h0, p_out, p_oe}, 16'h0003);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    {rst, pin, hfe, hfp, ia_in, ia_o, ia_oe, p_in, p_go, p_goe, tx, usel} = 12'hFC0;
    {r0, r1, pg} = 24'h0;
    req = '0;
    wt(8);
    rst = 1'b0;
    for (k = 0; k < 40 && crst !== 1'b0; k++) wt(1);
    t_timing();
    t_internal_data_space();
    t_xdata();
    t_pins();
    test_done();
  end
endmodule
